// [design/ivp_arb.sv]
`timescale 1ns/1ps

// ==========================================================
// Picks the pending line with the numerically smallest level;
// among equal levels the smallest line number wins.
module ivp_arb #(
	parameter int N = 24,
	parameter int NW = 5
) (
	// Pending lines and their level fields.
	input wire logic [N-1:0] i_pend,
	input wire logic [2*N-1:0] i_lvls,
	// Winner.
	output logic o_found,
	output logic [NW-1:0] o_num,
	output logic [1:0] o_lvl
);

	// Forward scan with strict compare keeps the lowest number on ties.
	always_comb begin
		o_found = 1'b0;
		o_num = '0;
		o_lvl = 2'b11;
		for (int j = 0; j < N; j++) begin
			if (i_pend[j] && (!o_found || (i_lvls[2*j +: 2] < o_lvl))) begin
				o_found = 1'b1;
				o_num = NW'(j);
				o_lvl = i_lvls[2*j +: 2];
			end
		end
	end

endmodule

// [design/ivp_ctrl.sv]
`timescale 1ns/1ps
`include "ivp_regs.svh"

// Function
// - two-bit levels; ties go to lowest number
// - compound timer 0 halves on lines 5, 6
// - compound timer 1 upper 14, lower 22
// - pulser 0 hi 12, lo 13; 16-bit 15
// - pulse gen 1 lower 9, upper 10
// - reserved addresses: read zero, writes dropped
// - six level registers, read/write, reset all ones
module ivp_ctrl (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Peripheral requests.
	input wire ivp_pkg::ivp_src_s i_src,
	// Level register access and core interrupt mask level.
	input wire ivp_pkg::ivp_acc_s i_acc,
	input wire logic [1:0] i_cpu_ilm,
	// Read data and request to the core.
	output logic [7:0] o_lvl_rdata,
	output ivp_pkg::ivp_req_s o_req
);

	ivp_pkg::ivp_state_s st_r;
	ivp_pkg::ivp_state_s st_nxt;
	logic [23:0] lines;
	logic [47:0] lvls;
	logic in_win;
	logic [15:0] offs;
	logic [2:0] idx;
	logic found;
	logic [4:0] win_num;
	logic [1:0] win_lvl;

	// ==========================================================
	// Source to line mapping.

	// External channels share lines in pairs; unused lines are forced low.
	// Named source line numbers live in the header; external lines 0 to 3 are set by the loop here.
	always_comb begin
		lines = '0;
		for (int k = 0; k < 4; k++) begin
			lines[k] = i_src.ext[k] | i_src.ext[k+4];
		end
		lines[`IVP_LN_UART_SIO] = i_src.uart_sio;
		lines[`IVP_LN_CT0_LO] = i_src.ct0_lo;
		lines[`IVP_LN_CT0_HI] = i_src.ct0_hi;
		lines[`IVP_LN_LIN_RX] = i_src.lin_rx;
		lines[`IVP_LN_LIN_TX] = i_src.lin_tx;
		lines[`IVP_LN_PPG1_LO] = i_src.ppg1_lo;
		lines[`IVP_LN_PPG1_HI] = i_src.ppg1_hi;
		lines[`IVP_LN_PPG0_HI] = i_src.ppg0_hi;
		lines[`IVP_LN_PPG0_LO] = i_src.ppg0_lo;
		lines[`IVP_LN_CT1_HI] = i_src.ct1_hi;
		lines[`IVP_LN_PPG16] = i_src.ppg16;
		lines[`IVP_LN_I2C] = i_src.i2c;
		lines[`IVP_LN_ADC] = i_src.adc;
		lines[`IVP_LN_TBT] = i_src.tbt;
		lines[`IVP_LN_WATCH] = i_src.watch;
		lines[`IVP_LN_CT1_LO] = i_src.ct1_lo;
		lines[`IVP_LN_FLASH] = i_src.flash;
		lines = lines & ~`IVP_UNUSED_MASK;
	end

	// Level fields of all registers, line j at bits 2j+1..2j.
	// One flat word lets the arbiter index the field of any line directly.
	assign lvls = st_r.lvl;

	// ==========================================================
	// Arbitration.
	// The arbiter is purely combinational; its winner is registered below.
	ivp_arb #(
		.N(`IVP_NLINES),
		.NW(5)
	) u_arb (
		.i_pend(lines),
		.i_lvls(lvls),
		.o_found(found),
		.o_num(win_num),
		.o_lvl(win_lvl)
	);

	// ==========================================================
	// Register window decode.
	// Only the six bytes of the window select a register; all else is reserved.
	assign offs = i_acc.addr - `IVP_LVL_BASE;
	assign in_win = (i_acc.addr >= `IVP_LVL_BASE) && (offs < 16'(`IVP_LVL_NREG));
	assign idx = offs[2:0];

	// Next state: level writes, read data, request and vector.
	// A read and a write in the same cycle return the old value.
	always_comb begin
		st_nxt = st_r;
		if (i_acc.wr && in_win) begin
			st_nxt.lvl[idx] = i_acc.wdata;
		end
		// Reserved addresses read as zero and drop writes.
		st_nxt.rdata = 8'h00;
		if (i_acc.rd && in_win) begin
			st_nxt.rdata = st_r.lvl[idx];
		end
		st_nxt.pend = lines;
		// The core takes a request only above its current mask level.
		st_nxt.out.req = found && (win_lvl < i_cpu_ilm);
		st_nxt.out.num = win_num;
		st_nxt.out.lvl = win_lvl;
		// The pair is recomputed every cycle, even when no request stands.
		st_nxt.out.vec_hi = `IVP_VEC_TOP - {10'h000, win_num, 1'b0};
		st_nxt.out.vec_lo = `IVP_VEC_TOP - {10'h000, win_num, 1'b0} + 16'h0001;
	end

	// State register; levels reset to all ones, the lowest priority.
	// The reset branch loads constants only; all other values come from st_nxt.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r.lvl <= {`IVP_LVL_NREG{`IVP_LVL_RST}};
			st_r.rdata <= 8'h00;
			st_r.pend <= '0;
			st_r.out <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from flip-flops, so the core never sees a glitch.
	assign o_lvl_rdata = st_r.rdata;
	assign o_req = st_r.out;

	// ==========================================================
	// Checks.
	// Outputs are compared with inputs sampled one edge earlier (two for the read-back check); the edge
	// right after reset is skipped where the state was still held then.

	// True when a line below num is pending at a level no worse than lvl, or a line above num at a better level.
	function automatic logic better_exists(input logic [23:0] p, input logic [47:0] l,
			input logic [4:0] num, input logic [1:0] lvl);
		logic r;
		r = 1'b0;
		for (int j = 0; j < 24; j++) begin
			if (j < int'(num) && p[j] && (l[2*j +: 2] <= lvl)) begin
				r = 1'b1;
			end
		end
		for (int j = 0; j < 24; j++) begin
			if (j > int'(num) && p[j] && (l[2*j +: 2] < lvl)) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// Vector and arbitration checks.
	vec_pair_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_req.req |-> (o_req.vec_lo == o_req.vec_hi + 16'h0001) && !o_req.vec_hi[0]
			&& (o_req.vec_hi == `IVP_VEC_TOP - {10'h000, o_req.num, 1'b0}))
		else $error("vector pair does not match request number");

	tie_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_req.req |-> st_r.pend[o_req.num]
			&& !better_exists(st_r.pend, $past(lvls), o_req.num, o_req.lvl))
		else $error("a better pending line was passed over");

	mask_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_req.req |-> o_req.lvl < $past(i_cpu_ilm))
		else $error("request raised at or below core mask level");

	win_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_req.req |-> o_req.lvl == 2'($past(lvls) >> {o_req.num, 1'b0}))
		else $error("request level differs from its line field");

	// Routing checks.
	ct0_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> (st_r.pend[`IVP_LN_CT0_LO] == $past(i_src.ct0_lo))
			&& (st_r.pend[`IVP_LN_CT0_HI] == $past(i_src.ct0_hi)))
		else $error("compound timer 0 routed to wrong line");

	ct1_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> (st_r.pend[`IVP_LN_CT1_HI] == $past(i_src.ct1_hi))
			&& (st_r.pend[`IVP_LN_CT1_LO] == $past(i_src.ct1_lo)))
		else $error("compound timer 1 routed to wrong line");

	ppg_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> (st_r.pend[`IVP_LN_PPG0_HI] == $past(i_src.ppg0_hi))
			&& (st_r.pend[`IVP_LN_PPG0_LO] == $past(i_src.ppg0_lo))
			&& (st_r.pend[`IVP_LN_PPG16] == $past(i_src.ppg16)))
		else $error("pulse generator 0 or 16-bit routed wrong");

	ppg1_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> (st_r.pend[`IVP_LN_PPG1_LO] == $past(i_src.ppg1_lo))
			&& (st_r.pend[`IVP_LN_PPG1_HI] == $past(i_src.ppg1_hi)))
		else $error("pulse generator 1 routed wrong");

	ext_pair_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> (st_r.pend[3:0]
			== ($past(i_src.ext[3:0]) | $past(i_src.ext[7:4]))))
		else $error("shared external line not pending");

	// Register window and unused line checks.
	rsvd_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_acc.wr && !in_win) |=> $stable(st_r.lvl))
		else $error("write to reserved address changed a level");

	lvl_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!(i_acc.wr && in_win) |=> $stable(st_r.lvl))
		else $error("level changed without a window write");

	lvl_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_acc.wr && in_win) |=> st_r.lvl[$past(idx)] == $past(i_acc.wdata))
		else $error("level register did not take written value");

	rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!(i_acc.rd && in_win) |=> o_lvl_rdata == 8'h00)
		else $error("read data not zero outside a window read");

	lvl_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_acc.wr && in_win) ##1 (i_acc.rd && (i_acc.addr == $past(i_acc.addr)) && !i_acc.wr)
			|=> o_lvl_rdata == $past(i_acc.wdata, 2))
		else $error("level register did not read back written value");

	unused_line_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_req.req |-> (o_req.num != 5'd11) && (o_req.num != 5'd17) && (o_req.num != 5'd21))
		else $error("unused line produced a request");

endmodule

// [design/ivp_pkg.sv]
package ivp_pkg;

	// ==========================================================
	// Peripheral request sources, one bit each, level sensitive.
	typedef struct packed {
		logic [7:0] ext;
		logic uart_sio;
		logic ct0_lo;
		logic ct0_hi;
		logic lin_rx;
		logic lin_tx;
		logic ppg1_lo;
		logic ppg1_hi;
		logic ppg0_hi;
		logic ppg0_lo;
		logic ct1_hi;
		logic ppg16;
		logic i2c;
		logic adc;
		logic tbt;
		logic watch;
		logic ct1_lo;
		logic flash;
	} ivp_src_s;

	// Level register access from the core.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ivp_acc_s;

	// Request presented to the core.
	typedef struct packed {
		logic req;
		logic [4:0] num;
		logic [1:0] lvl;
		logic [15:0] vec_hi;
		logic [15:0] vec_lo;
	} ivp_req_s;

	// Whole state of the controller.
	typedef struct packed {
		logic [5:0][7:0] lvl;
		logic [7:0] rdata;
		logic [23:0] pend;
		ivp_req_s out;
	} ivp_state_s;

endpackage

// [design/ivp_regs.svh]
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// ==========================================================
// Level-setting register window.
`define IVP_LVL_BASE 16'h0079
`define IVP_LVL_NREG 6
`define IVP_LVL_RST 8'hFF

// ==========================================================
// Request lines and vectors.
`define IVP_NLINES 24
`define IVP_VEC_TOP 16'hFFFA
`define IVP_UNUSED_MASK 24'h22_0800
`define IVP_LN_UART_SIO 4
`define IVP_LN_CT0_LO 5
`define IVP_LN_CT0_HI 6
`define IVP_LN_LIN_RX 7
`define IVP_LN_LIN_TX 8
`define IVP_LN_PPG1_LO 9
`define IVP_LN_PPG1_HI 10
`define IVP_LN_PPG0_HI 12
`define IVP_LN_PPG0_LO 13
`define IVP_LN_CT1_HI 14
`define IVP_LN_PPG16 15
`define IVP_LN_I2C 16
`define IVP_LN_ADC 18
`define IVP_LN_TBT 19
`define IVP_LN_WATCH 20
`define IVP_LN_CT1_LO 22
`define IVP_LN_FLASH 23

`endif

// [test/ivp_core_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Core model: holds a mask level and fetches the vector pair.
module ivp_core_model (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Request seen and mask level wanted.
	input wire ivp_pkg::ivp_req_s i_req,
	input wire logic [1:0] i_ilm_set,
	// Mask level and last fetched pair.
	output logic [1:0] o_cpu_ilm,
	output logic [31:0] o_fetch_r
);
	// The mask level follows the setting at once.
	assign o_cpu_ilm = i_ilm_set;

	// A taken request fetches the upper and lower byte addresses together on one edge.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fetch_r <= 32'h0000_0000;
		end else if (i_req.req) begin
			o_fetch_r <= {i_req.vec_hi, i_req.vec_lo};
		end
	end
endmodule

// [test/ivp_ctrl_bench.sv]
`timescale 1ns/1ps
`include "ivp_regs.svh"

module ivp_ctrl_bench;
	// ==========================================================
	// Signals and rows.
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	ivp_pkg::ivp_src_s i_src = '0;
	ivp_pkg::ivp_acc_s i_acc = '0;
	logic [1:0] ilm_set = 2'h3;
	logic [1:0] cpu_ilm;
	logic [7:0] rdata;
	logic [31:0] fetch;
	ivp_pkg::ivp_req_s req;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	typedef struct packed {logic [24:0] s; logic [1:0] m; logic q; logic [4:0] n;} ivp_row_s;
	ivp_row_s rows [14] = '{'{25'h0_8000, 2'h3, 1'h1, 5'h05}, '{25'h0_4000, 2'h3, 1'h1, 5'h06},
		'{25'h0_C000, 2'h3, 1'h1, 5'h05}, '{25'h0_0800, 2'h3, 1'h1, 5'h09},
		'{25'h0_0400, 2'h3, 1'h1, 5'h0A}, '{25'h0_0200, 2'h3, 1'h1, 5'h0C},
		'{25'h0_0100, 2'h3, 1'h1, 5'h0D}, '{25'h0_0040, 2'h3, 1'h1, 5'h0F},
		'{25'h0_0080, 2'h3, 1'h1, 5'h0E}, '{25'h0_0002, 2'h3, 1'h1, 5'h16},
		'{25'h0_0003, 2'h3, 1'h1, 5'h16}, '{25'h20_0000, 2'h3, 1'h1, 5'h00},
		'{25'h0_0000, 2'h3, 1'h0, 5'h00}, '{25'h0_8000, 2'h0, 1'h0, 5'h00}};

	ivp_ctrl u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_src(i_src), .i_acc(i_acc),
		.i_cpu_ilm(cpu_ilm), .o_lvl_rdata(rdata), .o_req(req));
	ivp_core_model u_core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req),
		.i_ilm_set(ilm_set), .o_cpu_ilm(cpu_ilm), .o_fetch_r(fetch));

	// Clock, and a cycle ceiling against hangs.
	always #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Tasks.
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One read or write strobe; read data is settled on return.
	task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_acc <= '{rd, !rd, a, d};
		@(posedge i_ref_clk);
		i_acc <= '0;
		#1;
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		logic [15:0] v;
		logic [39:0] e;
		#12;
		check({req}, 40'h00_0000_0000);
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			acc(1'b1, `IVP_LVL_BASE + 16'(k), 8'h00);
			check({32'h0, rdata}, 40'h00_0000_00FF);
			acc(1'b0, `IVP_LVL_BASE + 16'(k), 8'h00);
		end
		acc(1'b1, 16'h007E, 8'h00);
		check({32'h0, rdata}, 40'h00_0000_0000);
		acc(1'b0, 16'h007F, 8'h55);
		acc(1'b1, 16'h007F, 8'h00);
		check({32'h0, rdata}, 40'h00_0000_0000);
		$display("level register test done");
		foreach (rows[i]) begin
			@(posedge i_ref_clk);
			i_src <= rows[i].s;
			ilm_set <= rows[i].m;
			@(posedge i_ref_clk);
			#1;
			check({39'h0, req.req}, {39'h0, rows[i].q});
			if (rows[i].q) begin
				v = `IVP_VEC_TOP - {10'h000, rows[i].n, 1'b0};
				e = {1'b1, rows[i].n, 2'h0, v, v + 16'h0001};
				check(req, e);
				@(posedge i_ref_clk);
				#1;
				check({8'h00, fetch}, {8'h00, v, v + 16'h0001});
			end
		end
		$display("row test done");
		acc(1'b0, 16'h007A, 8'h04);
		@(posedge i_ref_clk);
		i_src <= 25'h0_C000;
		ilm_set <= 2'h3;
		repeat (2) @(posedge i_ref_clk);
		#1;
		check(req, {1'b1, 5'h06, 2'h0, 16'hFFEE, 16'hFFEF});
		@(posedge i_ref_clk);
		i_src <= 25'h0_8000;
		@(posedge i_ref_clk);
		#1;
		check(req, {1'b1, 5'h05, 2'h1, 16'hFFF0, 16'hFFF1});
		@(posedge i_ref_clk);
		i_acc <= '{1'b0, 1'b1, 16'h007B, 8'h5A};
		@(posedge i_ref_clk);
		i_acc <= '{1'b1, 1'b0, 16'h007B, 8'h00};
		@(posedge i_ref_clk);
		i_acc <= '0;
		#1;
		check({32'h0, rdata}, 40'h00_0000_005A);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		#1;
		check({req}, 40'h00_0000_0000);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		i_src <= 25'h0_C000;
		repeat (2) @(posedge i_ref_clk);
		#1;
		check({39'h0, req.req}, 40'h00_0000_0000);
		check({35'h0, req.num}, 40'h00_0000_0005);
		acc(1'b1, 16'h007A, 8'h00);
		check({32'h0, rdata}, 40'h00_0000_00FF);
		$display("level and reset test done");
		report_and_stop();
	end
endmodule
